// file: ecl_loader.sv
// Reset-time EEPROM/OTP configuration loader with host EEPROM access.
//
// Contract
// RULE1: Serial EEPROM of 256/512 bytes, always nine address bits shifted out.
// RULE2: After system reset load from EEPROM, answer config requests with retry.
// RULE3: Host may read, write and erase EEPROM bytes besides the reset load.
// RULE4: Programmed EEPROM beats OTP, OTP beats defaults.
// RULE5: Auto-load triggered by fundamental, hot, FLR, PM, POR, pin and soft reset.
// RULE6: Reset kind selects PCIe config, system CSRs, or both to program.
// RULE7: Some resets restore from the saved image without rereading memory.
// RULE8: EEPROM byte 0 of A5h or AAh means present and programmed.
// RULE9: EEPROM signature AAh loads only the MAC address.
// RULE10: OTP programmed only when byte 0 is F3h or F7h.
// RULE11: OTP F3h fetches from offset 1, F7h from offset 513.
// RULE12: Programmer keeps F3h images in bytes 0 to 511.
// RULE13: OTP without signature supplies nothing.
// RULE14: OTP has no MAC-only signature; AAh in OTP means unprogrammed.
// RULE15: No signature: finish and leave defaults.
// RULE16: Driver programs station address when nothing is configured.
// RULE17: OTP is 1K, read one byte at a time.
// RULE18: Soft-lite reset does not reload; only a host reload refreshes.
// RULE19: Load-done raised after programming; retry released only after it. The code drops retry in the same cycle that load-done rises.
// RULE20: Each EEPROM byte is a full command: select, opcode, address, data.
`include "ecl_cfg.svh"
module ecl_loader #(
  parameter int IMG_BYTES = `ECL_IMG_BYTES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        trig_pulse,
  input  wire logic [2:0]  trig_kind,
  input  wire logic        trig_restore,
  input  wire logic        host_req,
  input  wire logic [1:0]  host_op,
  input  wire logic [8:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic             host_done_r,
  output logic      [7:0]  host_rdata_r,
  input  wire logic        ee_do,
  output logic             ee_cs_r,
  output logic             ee_sck_r,
  output logic             ee_di_r,
  output logic      [9:0]  otp_addr_r,
  output logic             otp_rd_r,
  input  wire logic [7:0]  otp_rdata,
  input  wire logic        otp_rvalid,
  output logic             cfg_wr_r,
  output logic             cfg_pcie_r,
  output logic             cfg_csr_r,
  output logic      [5:0]  cfg_idx_r,
  output logic      [7:0]  cfg_data_r,
  output logic      [1:0]  cfg_src_r,
  output logic             load_done_r,
  output logic             crs_retry_r
);
  localparam int IW = $clog2(IMG_BYTES);

  // The image must hold the station address and still fit the six-bit config index.
  if (IMG_BYTES < `ECL_MAC_BYTES || IMG_BYTES > 64) begin : g_size_check
    $error("IMG_BYTES out of range");
  end

  ecl_pkg::ecl_state_t st_r;
  ecl_pkg::ecl_src_t   src_r;
  logic [1:0]  sel_r;           // Bit 1 programs PCIe config, bit 0 system CSRs.
  logic        img_ok_r;
  logic [9:0]  otp_base_r;
  logic [IW:0] cnt_r;
  logic [IW:0] lim_r;
  logic        byte_go_r;
  logic        byte_ack;
  logic [7:0]  byte_val;
  logic [8:0]  byte_addr;
  logic        rd_pending_r;
  logic [7:0]  img_rdata;
  logic        img_we;
  logic        ee_do_s1_r;
  logic        ee_do_s2_r;

  // Two-stage synchroniser on the serial data pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ee_do_s1_r <= 1'b0;
      ee_do_s2_r <= 1'b0;
    end else begin
      ee_do_s1_r <= ee_do;
      ee_do_s2_r <= ee_do_s1_r;
    end
  end

  // Serial engine: one complete command per byte, nine address bits always.
  logic [`ECL_CMD_BITS+7:0] sh_r;  // Start, opcode, address, then data.
  logic [4:0]  bit_r;
  logic [1:0]  div_r;
  logic        busy_r;
  logic        ack_r;
  logic [7:0]  rx_r;
  logic [1:0]  op_sel;
  logic [8:0]  addr_sel;
  assign op_sel   = (st_r == ecl_pkg::ST_HOST) ? host_op : `ECL_OP_READ;
  assign addr_sel = (st_r == ecl_pkg::ST_HOST) ? host_addr : byte_addr;
  assign byte_ack = ack_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sh_r <= '0; bit_r <= 5'h00; div_r <= 2'h0; busy_r <= 1'b0; ack_r <= 1'b0;
      ee_cs_r <= 1'b0; ee_sck_r <= 1'b0; ee_di_r <= 1'b0; rx_r <= 8'h00;
    end else begin
      ack_r <= 1'b0;
      if (!busy_r && byte_go_r && st_r != ecl_pkg::ST_OTP_SIG) begin
        // Start bit, opcode, nine address bits, then data (or don't care).
        sh_r      <= {1'b1, op_sel, addr_sel, host_wdata};  // [RULE1] [RULE20]
        bit_r     <= 5'h00;
        busy_r    <= 1'b1;
        ee_cs_r   <= 1'b1;
        div_r     <= 2'h0;
      end else if (busy_r) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h1) begin
          if (bit_r == 5'(`ECL_CMD_BITS + 8)) begin
            // Close only after the twentieth rise, so a write's last data bit is clocked in.
            busy_r   <= 1'b0;
            ack_r    <= 1'b1;
            ee_cs_r  <= 1'b0;
          end else begin
            ee_di_r  <= sh_r[`ECL_CMD_BITS+7];
          end
          ee_sck_r <= 1'b0;
        end else if (div_r == 2'h3) begin
          ee_sck_r <= 1'b1;
          sh_r     <= {sh_r[`ECL_CMD_BITS+6:0], 1'b0};
          if (bit_r >= 5'(`ECL_CMD_BITS)) begin
            rx_r <= {rx_r[6:0], ee_do_s2_r};  // [RULE20]
          end
          bit_r <= bit_r + 5'h01;
        end
      end
    end
  end
  assign byte_val = (src_r == ecl_pkg::SRC_OTP) ? otp_rdata : rx_r;

  // Image memory keeps the last loaded bytes for restore-only resets.
  assign img_we = (st_r == ecl_pkg::ST_FETCH) && (byte_ack || otp_rvalid);
  ecl_image_mem #(.DEPTH(IMG_BYTES)) u_img (
    .clk_sys(clk_sys),
    .we     (img_we),
    .waddr  (cnt_r[IW-1:0]),
    .wdata  (byte_val),
    .raddr  (cnt_r[IW-1:0]),
    .rdata  (img_rdata)
  );
  assign byte_addr = (st_r == ecl_pkg::ST_FETCH) ? 9'(cnt_r) + 9'h001 : 9'h000;

  // Main sequencer: signature checks, source precedence, fetch and apply.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= ecl_pkg::ST_IDLE; src_r <= ecl_pkg::SRC_NONE; sel_r <= 2'h3;
      img_ok_r <= 1'b0; otp_base_r <= 10'h000;
      cnt_r <= '0; lim_r <= '0; byte_go_r <= 1'b0; otp_rd_r <= 1'b0; otp_addr_r <= 10'h000;
      rd_pending_r <= 1'b0; load_done_r <= 1'b0; crs_retry_r <= 1'b1;
      cfg_wr_r <= 1'b0; cfg_idx_r <= 6'h00; cfg_data_r <= 8'h00;
      host_done_r <= 1'b0; host_rdata_r <= 8'h00;
    end else begin
      byte_go_r <= 1'b0; otp_rd_r <= 1'b0; cfg_wr_r <= 1'b0; host_done_r <= 1'b0;
      if (trig_pulse && st_r != ecl_pkg::ST_HOST) begin
        // A system reset outside a host access restarts the load; soft-lite never drives this.  [RULE5] [RULE18]
        sel_r        <= trig_kind[1:0];                                     // [RULE6]
        load_done_r  <= 1'b0;
        crs_retry_r  <= 1'b1;  // Every load holds config requests off.     [RULE2]
        cnt_r        <= '0;
        rd_pending_r <= 1'b0;
        if (trig_restore && img_ok_r) begin
          st_r <= ecl_pkg::ST_APPLY;                                        // [RULE7]
        end else begin
          st_r <= ecl_pkg::ST_EE_SIG;
          src_r <= ecl_pkg::SRC_EE;
          byte_go_r <= 1'b1;
        end
      end else begin
        case (st_r)
          ecl_pkg::ST_IDLE, ecl_pkg::ST_DONE: begin
            if (host_req) begin
              st_r <= ecl_pkg::ST_HOST;                                     // [RULE3]
              src_r <= ecl_pkg::SRC_EE;
              byte_go_r <= 1'b1;
            end
          end
          ecl_pkg::ST_HOST: begin
            if (byte_ack) begin
              host_rdata_r <= rx_r;
              host_done_r <= 1'b1;
              st_r <= ecl_pkg::ST_DONE;
            end
          end
          ecl_pkg::ST_EE_SIG: begin
            if (byte_ack) begin
              if (rx_r == `ECL_EE_SIG_FULL || rx_r == `ECL_EE_SIG_MAC) begin  // [RULE8] [RULE4]
                lim_r <= (rx_r == `ECL_EE_SIG_MAC) ? (IW+1)'(`ECL_MAC_BYTES)    // [RULE9]
                                                   : (IW+1)'(IMG_BYTES);
                st_r <= ecl_pkg::ST_FETCH;
                byte_go_r <= 1'b1;
              end else begin
                src_r <= ecl_pkg::SRC_OTP;
                st_r <= ecl_pkg::ST_OTP_SIG;
                otp_addr_r <= 10'h000;                                        // [RULE17]
                otp_rd_r <= 1'b1;
              end
            end
          end
          ecl_pkg::ST_OTP_SIG: begin
            if (otp_rvalid) begin
              if (otp_rdata == `ECL_OTP_SIG_LOW || otp_rdata == `ECL_OTP_SIG_HIGH) begin // [RULE10]
                otp_base_r <= (otp_rdata == `ECL_OTP_SIG_HIGH) ? `ECL_OTP_BASE_HIGH
                                                                 : `ECL_OTP_BASE_LOW; // [RULE11]
                otp_addr_r <= (otp_rdata == `ECL_OTP_SIG_HIGH) ? `ECL_OTP_BASE_HIGH
                                                                 : `ECL_OTP_BASE_LOW;
                lim_r <= (IW+1)'(IMG_BYTES);  // No MAC-only variant in OTP. [RULE14]
                otp_rd_r <= 1'b1;
                st_r <= ecl_pkg::ST_FETCH;
              end else begin
                src_r <= ecl_pkg::SRC_NONE;                                   // [RULE13] [RULE15]
                st_r <= ecl_pkg::ST_WAIT;
              end
            end
          end
          ecl_pkg::ST_FETCH: begin
            if (byte_ack || otp_rvalid) begin
              cnt_r <= cnt_r + (IW+1)'(1);
              if (cnt_r + (IW+1)'(1) == lim_r) begin
                img_ok_r <= 1'b1;
                cnt_r <= '0;
                st_r <= ecl_pkg::ST_APPLY;
              end else if (src_r == ecl_pkg::SRC_OTP) begin
                otp_addr_r <= otp_base_r + 10'(cnt_r) + 10'h001;
                otp_rd_r <= 1'b1;
              end else begin
                byte_go_r <= 1'b1;
              end
            end
          end
          ecl_pkg::ST_APPLY: begin
            // The read port lags by one cycle; pending marks valid data.
            rd_pending_r <= 1'b1;
            if (rd_pending_r) begin
              cfg_wr_r <= 1'b1;                                               // [RULE6]
              cfg_idx_r <= 6'(cnt_r);
              cfg_data_r <= img_rdata;
              cnt_r <= cnt_r + (IW+1)'(1);
              rd_pending_r <= 1'b0;
              if (cnt_r + (IW+1)'(1) == lim_r) begin
                st_r <= ecl_pkg::ST_WAIT;
              end
            end
          end
          ecl_pkg::ST_WAIT: begin
            load_done_r <= 1'b1;                                              // [RULE19]
            st_r <= ecl_pkg::ST_DONE;
          end
          default: st_r <= ecl_pkg::ST_IDLE;
        endcase
        if (st_r == ecl_pkg::ST_WAIT) begin
          crs_retry_r <= 1'b0;                                                // [RULE2] [RULE19]
        end
      end
    end
  end

  assign cfg_pcie_r = sel_r[1];
  assign cfg_csr_r  = sel_r[0];
  assign cfg_src_r  = src_r;

  // Retry must not drop while the load is still running.
  retry_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE19]
    $fell(crs_retry_r) |-> load_done_r) else $error("retry released before done");
  // Every accepted trigger puts config requests back on retry and clears done.
  retry_set_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    (trig_pulse && st_r != ecl_pkg::ST_HOST) |=> (crs_retry_r && !load_done_r))
    else $error("load started without retry");
  sig_reject_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
    (st_r == ecl_pkg::ST_EE_SIG && byte_ack && rx_r != `ECL_EE_SIG_FULL
     && rx_r != `ECL_EE_SIG_MAC) |=> st_r == ecl_pkg::ST_OTP_SIG)
    else $error("bad signature accepted");
  // A programmed EEPROM must be used without ever looking at the OTP.
  ee_first_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
    (st_r == ecl_pkg::ST_EE_SIG && byte_ack && !trig_pulse
     && (rx_r == `ECL_EE_SIG_FULL || rx_r == `ECL_EE_SIG_MAC))
    |=> (st_r == ecl_pkg::ST_FETCH && src_r == ecl_pkg::SRC_EE))
    else $error("eeprom not preferred");
  mac_only_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
    (st_r == ecl_pkg::ST_EE_SIG && byte_ack && !trig_pulse && rx_r == `ECL_EE_SIG_MAC)
    |=> lim_r == (IW+1)'(`ECL_MAC_BYTES)) else $error("mac-only load too long");
  otp_base_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE11]
    (st_r == ecl_pkg::ST_OTP_SIG && otp_rvalid && otp_rdata == `ECL_OTP_SIG_HIGH)
    |=> otp_addr_r == `ECL_OTP_BASE_HIGH) else $error("wrong otp base");
  otp_blank_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE14]
    (st_r == ecl_pkg::ST_OTP_SIG && otp_rvalid && otp_rdata == `ECL_EE_SIG_MAC)
    |=> src_r == ecl_pkg::SRC_NONE) else $error("otp mac-only accepted");
  // A frame is exactly twenty clock periods plus the closing step, then deselects.
  cs_frame_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE20]
    $rose(ee_cs_r) |-> ##81 ee_cs_r ##1 !ee_cs_r) else $error("serial command wrong length");
endmodule

// file: ecl_cfg.svh
// Constants for the configuration loader: signatures, offsets, serial command layout.
`ifndef ECL_CFG_SVH
`define ECL_CFG_SVH
`define ECL_EE_ADDR_W      9
`define ECL_OTP_ADDR_W     10
`define ECL_EE_SIG_FULL    8'hA5
`define ECL_EE_SIG_MAC     8'hAA
`define ECL_OTP_SIG_LOW    8'hF3
`define ECL_OTP_SIG_HIGH   8'hF7
`define ECL_OTP_BASE_LOW   10'h001
`define ECL_OTP_BASE_HIGH  10'h201
`define ECL_MAC_BYTES      6
`define ECL_IMG_BYTES      64
`define ECL_OP_READ        2'h2
`define ECL_OP_WRITE       2'h1
`define ECL_OP_ERASE       2'h3
`define ECL_CMD_BITS       12
`define ECL_SCK_DIV        4
`endif

// file: ecl_pkg.sv
// Types shared by the configuration loader files.
package ecl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_EE_SIG = 4'h1,
    ST_OTP_SIG= 4'h2,
    ST_FETCH  = 4'h3,
    ST_APPLY  = 4'h4,
    ST_DONE   = 4'h5,
    ST_HOST   = 4'h6,
    ST_WAIT   = 4'h7
  } ecl_state_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_EE   = 2'h1,
    SRC_OTP  = 2'h2
  } ecl_src_t;
endpackage

// file: ecl_image_mem.sv
// Small image memory holding the last loaded configuration bytes.
module ecl_image_mem #(
  parameter int DEPTH = 64
) (
  input  wire logic                     clk_sys,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [7:0]               wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [7:0]               rdata
);
  // At least one address bit is needed; a single word would need no address.
  if (DEPTH < 2) begin : g_depth_check
    $error("DEPTH out of range");
  end

  logic [7:0] mem [DEPTH];

  // Registered read keeps the output timing independent of the address path.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: ecl_mem_model.sv
// Behavioural serial EEPROM and OTP array that sit across from the loader.
`include "ecl_cfg.svh"
module ecl_mem_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       ee_cs_r,
  input  wire logic       ee_sck_r,
  input  wire logic       ee_di_r,
  output logic            ee_do,
  input  wire logic [9:0] otp_addr_r,
  input  wire logic       otp_rd_r,
  output logic      [7:0] otp_rdata,
  output logic            otp_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  ee_mem [0:511];
  logic [7:0]  otp_mem [0:1023]; // A 1K array that is read one byte at a time.
  logic [11:0] cmd;
  logic [7:0]  wsh;
  logic        do_bit = 1'b0;
  logic        idle_r = 1'b0;
  logic [3:0]  cnt;
  logic [9:0]  a_q;
  int          nbit;

  // The data line has no pull, so when deselected it toggles instead of holding a stale bit.
  assign ee_do = ee_cs_r ? do_bit : idle_r;

  // Pattern for the released data line.
  always @(posedge clk_sys) idle_r <= ~idle_r;

  // Command bits are taken at each rise; read data changes just after a rise, for the next one.
  always @(posedge ee_sck_r or negedge ee_cs_r) begin
    if (!ee_cs_r) begin
      nbit = 0;
    end else begin
      if (nbit < 12) cmd = {cmd[10:0], ee_di_r};
      else wsh = {wsh[6:0], ee_di_r};
      nbit = nbit + 1;
      do_bit = ~do_bit;
      if (nbit >= 12 && nbit < 20 && cmd[10:9] == `ECL_OP_READ) do_bit = ee_mem[cmd[8:0]][19 - nbit];
      if (nbit == 20 && cmd[10:9] == `ECL_OP_WRITE) ee_mem[cmd[8:0]] = wsh;
      if (nbit == 20 && cmd[10:9] == `ECL_OP_ERASE) ee_mem[cmd[8:0]] = 8'hFF;
    end
  end

  // OTP reads answer after one cycle, or after six when slow is set.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      otp_rvalid <= 1'b0;
      otp_rdata <= 8'h00;
      a_q <= 10'h000;
    end else begin
      otp_rvalid <= (cnt == 4'h1);
      otp_rdata <= (cnt == 4'h1) ? otp_mem[a_q] : ~otp_rdata;
      if (otp_rd_r) begin
        a_q <= otp_addr_r;
        cnt <= slow ? 4'h6 : 4'h1;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// file: ecl_tb.sv
// Self-checking testbench for the configuration loader.
`include "ecl_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  logic        trig_pulse = 1'b0;
  logic [2:0]  trig_kind = 3'h0;
  logic        trig_restore = 1'b0;
  logic        host_req = 1'b0;
  logic [1:0]  host_op = 2'h0;
  logic [8:0]  host_addr = 9'h000;
  logic [7:0]  host_wdata = 8'h00;
  logic        host_done_r, ee_do, ee_cs_r, ee_sck_r, ee_di_r, otp_rd_r, otp_rvalid;
  logic        cfg_wr_r, cfg_pcie_r, cfg_csr_r, load_done_r, crs_retry_r;
  logic [7:0]  host_rdata_r, otp_rdata, cfg_data_r;
  logic [9:0]  otp_addr_r;
  logic [5:0]  cfg_idx_r;
  logic [1:0]  cfg_src_r;
  logic [15:0] wr_q[$];
  logic        cs_q = 1'b0;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          cs_rises = 0;

  ecl_loader #(.IMG_BYTES(64)) DUT (.clk_sys, .rst, .trig_pulse, .trig_kind, .trig_restore,
    .host_req, .host_op, .host_addr, .host_wdata, .host_done_r, .host_rdata_r, .ee_do,
    .ee_cs_r, .ee_sck_r, .ee_di_r, .otp_addr_r, .otp_rd_r, .otp_rdata, .otp_rvalid,
    .cfg_wr_r, .cfg_pcie_r, .cfg_csr_r, .cfg_idx_r, .cfg_data_r, .cfg_src_r,
    .load_done_r, .crs_retry_r);
  ecl_mem_model PM (.clk_sys, .rst, .slow, .ee_cs_r, .ee_sck_r, .ee_di_r, .ee_do,
    .otp_addr_r, .otp_rd_r, .otp_rdata, .otp_rvalid);

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Fires one load and compares every configuration write with the chosen source bytes.
  task automatic load_chk(input logic [2:0] kind, input logic rs, input logic [1:0] src,
                          input int n, input logic otp, input int base);
    int         cs0;
    int         k;
    logic [7:0] e;
    wr_q = {};
    cs0 = cs_rises;
    @(posedge clk_sys);
    trig_kind <= kind;
    trig_restore <= rs;
    trig_pulse <= 1'b1;
    @(posedge clk_sys);
    trig_pulse <= 1'b0;
    #1;
    for (k = 0; k < 20000 && load_done_r !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    repeat (2) @(posedge clk_sys);
    #1;
    chk("source", 16'(src), 16'(cfg_src_r));
    chk("write count", 16'(n), 16'(wr_q.size()));
    for (k = 0; k < n && k < wr_q.size(); k++) begin
      e = otp ? PM.otp_mem[base + k] : PM.ee_mem[base + k];
      chk("config write", {k[5:0], kind[1:0], e}, wr_q[k]);
    end
    chk("retry", 16'h0, 16'(crs_retry_r));
    if (rs) chk("eeprom reread", 16'h0, 16'(cs_rises - cs0));
  endtask

  // One host access; a read compares the returned byte.
  task automatic host_chk(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
                          input logic [7:0] exp);
    int k;
    @(posedge clk_sys);
    host_op <= op;
    host_addr <= a;
    host_wdata <= d;
    host_req <= 1'b1;
    @(posedge clk_sys);
    host_req <= 1'b0;
    for (k = 0; k < 400 && host_done_r !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("host done", 16'h1, 16'(host_done_r));
    if (op == `ECL_OP_READ) chk("host read", 16'(exp), 16'(host_rdata_r));
  endtask

  task automatic sc_ee_full;
    load_chk(3'b011, 1'b0, ecl_pkg::SRC_EE, 64, 1'b0, 1);
  endtask

  // Byte 0 is blanked first, so a reread would find no EEPROM signature and load the OTP instead.
  task automatic sc_restore;
    PM.ee_mem[0] = 8'h00;
    load_chk(3'b010, 1'b1, ecl_pkg::SRC_EE, 64, 1'b0, 1);
  endtask

  task automatic sc_otp_low;
    load_chk(3'b001, 1'b0, ecl_pkg::SRC_OTP, 64, 1'b1, 1);
  endtask

  // The lower image is superseded by the upper one, fetched with a slow OTP.
  task automatic sc_otp_high;
    PM.otp_mem[0] = `ECL_OTP_SIG_HIGH;
    slow = 1'b1;
    load_chk(3'b011, 1'b0, ecl_pkg::SRC_OTP, 64, 1'b1, 513);
    slow = 1'b0;
  endtask

  task automatic sc_ee_mac;
    PM.ee_mem[0] = `ECL_EE_SIG_MAC;
    load_chk(3'b011, 1'b0, ecl_pkg::SRC_EE, 6, 1'b0, 1);
  endtask

  // No source: the station address is left for the driver to write.
  task automatic sc_no_sig;
    PM.ee_mem[0] = 8'hA4;
    PM.otp_mem[0] = `ECL_EE_SIG_MAC;
    load_chk(3'b011, 1'b0, ecl_pkg::SRC_NONE, 0, 1'b0, 0);
  endtask

  task automatic sc_host;
    host_chk(`ECL_OP_WRITE, 9'h1FF, 8'h5A, 8'h00);
    host_chk(`ECL_OP_READ, 9'h1FF, 8'h00, 8'h5A);
    host_chk(`ECL_OP_READ, 9'h0FF, 8'h00, 8'hEA);
    host_chk(`ECL_OP_ERASE, 9'h1FF, 8'h00, 8'h00);
    host_chk(`ECL_OP_READ, 9'h1FF, 8'h00, 8'hFF);
  endtask

  // Free-running system clock.
  always #12.5 clk_sys = ~clk_sys;

  // Records writes, counts chip selects, guards the retry hold and cuts off a hang.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    cs_q <= ee_cs_r;
    if (ee_cs_r === 1'b1 && cs_q !== 1'b1) cs_rises <= cs_rises + 1;
    if (cfg_wr_r === 1'b1) wr_q.push_back({cfg_idx_r, cfg_pcie_r, cfg_csr_r, cfg_data_r});
    if (!rst && crs_retry_r !== 1'b1 && load_done_r !== 1'b1) chk("retry hold", 16'h1, 16'h0);
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Main sequence; both memories are programmed so that the EEPROM must win.
  initial begin
    for (int i = 0; i < 512; i++) PM.ee_mem[i] = 8'(i * 29 + 7);
    for (int i = 0; i < 1024; i++) PM.otp_mem[i] = 8'(i * 13 + 3);
    PM.ee_mem[0] = `ECL_EE_SIG_FULL;
    PM.otp_mem[0] = `ECL_OTP_SIG_LOW;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("retry at reset", 16'h1, 16'(crs_retry_r));
    chk("done at reset", 16'h0, 16'(load_done_r));
    sc_ee_full();
    sc_restore();
    sc_otp_low();
    sc_otp_high();
    sc_ee_mac();
    sc_no_sig();
    sc_host();
    tally_and_finish();
  end
endmodule
